// >>> mwq_regs.vh
`ifndef MWQ_REGS_VH
`define MWQ_REGS_VH
// register byte offsets, counter n at base + 4*n
`define MWQ_CTL0_OFF      8'h00
`define MWQ_CTRLO0_OFF    8'h10
`define MWQ_CTRHI0_OFF    8'h20
`define MWQ_STAT_OFF      8'h30
`define MWQ_CTL_RESET     32'h00000000
// control fields
`define MWQ_EV_MSB        7
`define MWQ_UM_LSB        8
`define MWQ_UM_MSB        15
`define MWQ_CLR_BIT       17
`define MWQ_EN_BIT        22
// event codes
`define MWQ_EV_STRV_REL   8'hDE
`define MWQ_EV_STRV_FILL  8'hD8
`define MWQ_EV_MARKED     8'hDD
`define MWQ_EV_LOOKUP     8'hD3
`define MWQ_EV_FULL_CH0   8'h22
`define MWQ_EV_FULL_CH1   8'h16
`define MWQ_EV_NONEMPTY   8'h21
`define MWQ_EV_ALLOC      8'h20
`define MWQ_EV_FILL_CH0   8'h82
`define MWQ_EV_FILL_CH1   8'h83
`define MWQ_EV_RD_MATCH   8'h23
`define MWQ_EV_WR_MATCH   8'h24
// largest increment per cycle
`define MWQ_MAX_ONE       9'h001
`define MWQ_MAX_STRV_FILL 9'h03F
`define MWQ_MAX_MARKED    9'h008
// sizes
`define MWQ_WQ_DEPTH      40
`define MWQ_WQ_FULL_CNT   6'h28
`define MWQ_CNT_W         6
`define MWQ_ADDR_W        16
`define MWQ_DATA_W        32
`define MWQ_BE_W          4
`define MWQ_CTR_W         48
`define MWQ_INC_W         7
`endif

// >>> mwq_event_counter.v
`include "mwq_regs.vh"
`default_nettype none
// one 48-bit event counter with software preset and clear
module mwq_event_counter (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    enable,
  input  wire                    clear,
  input  wire [`MWQ_INC_W-1:0]   inc,
  input  wire                    load_lo,
  input  wire                    load_hi,
  input  wire [31:0]             wdata,
  output reg  [`MWQ_CTR_W-1:0]   count_reg
);
  wire [`MWQ_CTR_W-1:0] count_next;
  // software load beats clear beats counting
  assign count_next = load_lo ? {count_reg[47:32], wdata} :
                      load_hi ? {wdata[15:0], count_reg[31:0]} :
                      clear   ? {`MWQ_CTR_W{1'b0}} :
                      enable  ? count_reg + {41'h0, inc} : count_reg;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= {`MWQ_CTR_W{1'b0}};
    else
      count_reg <= count_next;
  end
endmodule // mwq_event_counter
`default_nettype wire

// >>> mwq_write_hold_queue.v
`include "mwq_regs.vh"
`default_nettype none
// write hold queue of one pseudo channel; addresses stay unique through merging
module mwq_write_hold_queue (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire                   wr_valid,
  input  wire [`MWQ_ADDR_W-1:0] wr_addr,
  input  wire [`MWQ_DATA_W-1:0] wr_data,
  input  wire [`MWQ_BE_W-1:0]   wr_be,
  output wire                   wr_ready,
  output reg                    wr_posted_reg,
  output reg                    wr_alloc_reg,
  output reg                    wr_match_reg,
  input  wire                   rd_valid,
  input  wire [`MWQ_ADDR_W-1:0] rd_addr,
  output reg                    rd_done_reg,
  output reg                    rd_hit_reg,
  output reg  [`MWQ_DATA_W-1:0] rd_data_reg,
  output wire                   iss_valid,
  output wire [`MWQ_ADDR_W-1:0] iss_addr,
  output wire [`MWQ_DATA_W-1:0] iss_data,
  output wire [`MWQ_BE_W-1:0]   iss_be,
  input  wire                   iss_ready,
  output reg  [`MWQ_CNT_W-1:0]  occ_reg,
  output wire                   full,
  output wire                   nonempty
);
  localparam D = `MWQ_WQ_DEPTH;
  reg  [`MWQ_ADDR_W-1:0] addr_mem [0:D-1];
  reg  [`MWQ_DATA_W-1:0] data_mem [0:D-1];
  reg  [`MWQ_BE_W-1:0]   be_mem   [0:D-1];
  reg  [D-1:0]           vld_reg;
  wire [D-1:0]           wr_hit_vec;
  wire [D-1:0]           rd_hit_vec;
  reg  [5:0]             free_idx, iss_idx, wr_idx, rd_idx;
  integer                i;
  integer                j;
  // address search of every entry
  genvar g;
  generate
    for (g = 0; g < D; g = g + 1)
    begin : g_cam
      assign wr_hit_vec[g] = vld_reg[g] & (addr_mem[g] == wr_addr);
      assign rd_hit_vec[g] = vld_reg[g] & (addr_mem[g] == rd_addr);
    end
  endgenerate
  // lowest index wins each search
  always @*
  begin
    free_idx = 6'h00; iss_idx = 6'h00; wr_idx = 6'h00; rd_idx = 6'h00;
    for (i = D - 1; i >= 0; i = i - 1)
    begin
      if (!vld_reg[i]) free_idx = i[5:0];
      if (vld_reg[i]) iss_idx = i[5:0];
      if (wr_hit_vec[i]) wr_idx = i[5:0];
      if (rd_hit_vec[i]) rd_idx = i[5:0];
    end
  end
  wire wr_hit  = |wr_hit_vec;
  assign full     = (occ_reg == `MWQ_WQ_FULL_CNT);
  assign nonempty = |vld_reg;
  assign wr_ready = wr_hit | ~full;
  wire wr_fire = wr_valid & wr_ready;
  // hold back the entry a same-cycle write merges into; unique addresses make
  // any issue order legal against older writes
  assign iss_valid = nonempty & ~(wr_valid & wr_hit & (wr_idx == iss_idx));
  assign iss_addr  = addr_mem[iss_idx];
  assign iss_data  = data_mem[iss_idx];
  assign iss_be    = be_mem[iss_idx];
  wire iss_fire = iss_valid & iss_ready;
  wire alloc    = wr_fire & ~wr_hit;
  wire [5:0] tgt = wr_hit ? wr_idx : free_idx;
  // entry storage; merge keeps bytes the new write leaves out
  always @(posedge clk)
  begin
    if (wr_fire)
    begin
      addr_mem[tgt] <= wr_addr;
      be_mem[tgt]   <= wr_hit ? (be_mem[tgt] | wr_be) : wr_be;
      for (j = 0; j < `MWQ_BE_W; j = j + 1)
        if (wr_be[j]) data_mem[tgt][8*j +: 8] <= wr_data[8*j +: 8];
    end
  end
  // entry is freed only by its issue to dram
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vld_reg <= {D{1'b0}}; occ_reg <= 6'h00;
      wr_posted_reg <= 1'b0; wr_alloc_reg <= 1'b0; wr_match_reg <= 1'b0;
      rd_done_reg <= 1'b0; rd_hit_reg <= 1'b0; rd_data_reg <= 32'h00000000;
    end
    else
    begin
      if (iss_fire) vld_reg[iss_idx] <= 1'b0;
      if (alloc) vld_reg[free_idx] <= 1'b1;
      occ_reg <= occ_reg + {5'h00, alloc} - {5'h00, iss_fire};
      wr_posted_reg <= wr_fire;
      wr_alloc_reg  <= alloc;
      wr_match_reg  <= wr_fire & wr_hit;
      rd_done_reg   <= rd_valid;
      rd_hit_reg    <= rd_valid & (|rd_hit_vec);
      rd_data_reg   <= data_mem[rd_idx];
    end
  end
endmodule // mwq_write_hold_queue
`default_nettype wire

// >>> mwq_event_select.v
// Chosen here: the APB slave port and the register addresses.
`include "mwq_regs.vh"
`default_nettype none
module mwq_event_select (
  input  wire         pclk,
  input  wire         presetn,
  // apb slave
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata_reg,
  output wire         pready,
  output wire         pslverr,
  // write requests, two pseudo channels packed low channel first
  input  wire [1:0]   wq_wr_valid,
  input  wire [31:0]  wq_wr_addr,
  input  wire [63:0]  wq_wr_data,
  input  wire [7:0]   wq_wr_be,
  output wire [1:0]   wq_wr_ready,
  output wire [1:0]   wq_wr_posted,
  // reads searching the queue
  input  wire [1:0]   wq_rd_valid,
  input  wire [31:0]  wq_rd_addr,
  output wire [1:0]   wq_rd_done,
  output wire [1:0]   wq_rd_hit,
  output wire [63:0]  wq_rd_data,
  // writes leaving for dram
  output wire [1:0]   wq_iss_valid,
  output wire [31:0]  wq_iss_addr,
  output wire [63:0]  wq_iss_data,
  output wire [7:0]   wq_iss_be,
  input  wire [1:0]   wq_iss_ready,
  // scoreboard and tag check strobes
  input  wire [4:0]   sb_starve_release,
  input  wire [29:0]  sb_starve_fill_cnt,
  input  wire [7:0]   sb_marked_req,
  input  wire [4:0]   near_cache_lookup
);
  ////////////////////////////////////////////////////////////////////////////
  // write hold queues
  wire [1:0]  wq_full;
  wire [1:0]  wq_nonempty;
  wire [1:0]  wq_alloc;
  wire [1:0]  wq_wr_match;
  wire [11:0] wq_occ;
  wire [1:0]  wq_rd_match;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ch
      mwq_write_hold_queue u_queue (
        .clk           (pclk),
        .rst_n         (presetn),
        .wr_valid      (wq_wr_valid[ch]),
        .wr_addr       (wq_wr_addr[16*ch +: 16]),
        .wr_data       (wq_wr_data[32*ch +: 32]),
        .wr_be         (wq_wr_be[4*ch +: 4]),
        .wr_ready      (wq_wr_ready[ch]),
        .wr_posted_reg (wq_wr_posted[ch]),
        .wr_alloc_reg  (wq_alloc[ch]),
        .wr_match_reg  (wq_wr_match[ch]),
        .rd_valid      (wq_rd_valid[ch]),
        .rd_addr       (wq_rd_addr[16*ch +: 16]),
        .rd_done_reg   (wq_rd_done[ch]),
        .rd_hit_reg    (wq_rd_hit[ch]),
        .rd_data_reg   (wq_rd_data[32*ch +: 32]),
        .iss_valid     (wq_iss_valid[ch]),
        .iss_addr      (wq_iss_addr[16*ch +: 16]),
        .iss_data      (wq_iss_data[32*ch +: 32]),
        .iss_be        (wq_iss_be[4*ch +: 4]),
        .iss_ready     (wq_iss_ready[ch]),
        .occ_reg       (wq_occ[6*ch +: 6]),
        .full          (wq_full[ch]),
        .nonempty      (wq_nonempty[ch])
      );
      // a read match is a search hit, reported with the returned data
      assign wq_rd_match[ch] = wq_rd_hit[ch];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // number of set bits in a byte
  function [8:0] pop8;
    input [7:0] v;
    integer k;
    begin
      pop8 = 9'h000;
      for (k = 0; k < 8; k = k + 1)
        pop8 = pop8 + {8'h00, v[k]};
    end
  endfunction

  // cap a raw per-cycle sum at the event's largest increment
  function [`MWQ_INC_W-1:0] cap;
    input [8:0] raw;
    input [8:0] lim;
    begin
      cap = (raw > lim) ? lim[6:0] : raw[6:0];
    end
  endfunction

  // starvation fill counts of the sets that the mask selects
  function [8:0] fill_sum;
    input [4:0]  um;
    input [29:0] cnt;
    integer k;
    begin
      fill_sum = 9'h000;
      for (k = 0; k < 5; k = k + 1)
        if (um[k]) fill_sum = fill_sum + {3'h0, cnt[6*k +: 6]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, so the access cycle is the completion
  wire        acc    = psel & penable;
  wire        setup  = psel & ~penable;
  wire        wr_acc = acc & pwrite;
  wire        in_map = (paddr[1:0] == 2'b00) && (paddr <= `MWQ_STAT_OFF);

  assign pready  = 1'b1;
  // misaligned or past the last register answers with an error
  assign pslverr = acc & ~in_map;

  wire [127:0] ctl_flat;
  wire [191:0] cnt_flat;

  ////////////////////////////////////////////////////////////////////////////
  // one counter per control register
  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1)
    begin : g_ctr
      reg  [31:0]             ctl_reg;
      reg  [`MWQ_INC_W-1:0]   inc;
      wire [7:0]              code = ctl_reg[`MWQ_EV_MSB:0];
      wire [7:0]              um   = ctl_reg[`MWQ_UM_MSB:`MWQ_UM_LSB];
      // byte offset of this counter's registers, cut to the bus width on purpose
      localparam integer      OFF_I = 4 * c;
      wire [7:0]              off  = OFF_I[7:0];
      wire                    hit_ctl = wr_acc && (paddr == `MWQ_CTL0_OFF + off);
      wire                    hit_lo  = wr_acc && (paddr == `MWQ_CTRLO0_OFF + off);
      wire                    hit_hi  = wr_acc && (paddr == `MWQ_CTRHI0_OFF + off);

      // control register; the clear bit acts once and reads back zero
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          ctl_reg <= `MWQ_CTL_RESET;
        else if (hit_ctl)
          ctl_reg <= pwdata & ~(32'h00000001 << `MWQ_CLR_BIT);
      end

      // event code and mask pick the increment of this cycle
      always @*
      begin
        inc = 7'h00;
        case (code)
          `MWQ_EV_STRV_REL:
            inc = cap(pop8({3'b000, um[4:0] & sb_starve_release}),
                      `MWQ_MAX_ONE);
          `MWQ_EV_STRV_FILL:
            inc = cap(fill_sum(um[4:0], sb_starve_fill_cnt),
                      `MWQ_MAX_STRV_FILL);
          `MWQ_EV_MARKED:
            inc = cap(pop8(um & sb_marked_req), `MWQ_MAX_MARKED);
          `MWQ_EV_LOOKUP:
            inc = cap(pop8({3'b000, um[4:0] & near_cache_lookup}),
                      `MWQ_MAX_ONE);
          `MWQ_EV_FULL_CH0:
            inc = {6'h00, wq_full[0]};
          `MWQ_EV_FULL_CH1:
            inc = {6'h00, wq_full[1]};
          `MWQ_EV_NONEMPTY:
            inc = cap(pop8({6'h00, um[1:0] & wq_nonempty}), `MWQ_MAX_ONE);
          `MWQ_EV_ALLOC:
            inc = cap(pop8({6'h00, um[1:0] & wq_alloc}), `MWQ_MAX_ONE);
          `MWQ_EV_FILL_CH0:
            inc = {1'b0, wq_occ[5:0]};
          `MWQ_EV_FILL_CH1:
            inc = {1'b0, wq_occ[11:6]};
          `MWQ_EV_RD_MATCH:
            inc = cap(pop8({6'h00, um[1:0] & wq_rd_match}), `MWQ_MAX_ONE);
          `MWQ_EV_WR_MATCH:
            inc = cap(pop8({6'h00, um[1:0] & wq_wr_match}), `MWQ_MAX_ONE);
          default:
            inc = 7'h00;
        endcase
      end

      // counters 0-3 all accept every event of this block
      mwq_event_counter u_ctr (
        .clk       (pclk),
        .rst_n     (presetn),
        .enable    (ctl_reg[`MWQ_EN_BIT]),
        .clear     (hit_ctl & pwdata[`MWQ_CLR_BIT]),
        .inc       (inc),
        .load_lo   (hit_lo),
        .load_hi   (hit_hi),
        .wdata     (pwdata),
        .count_reg (cnt_flat[48*c +: 48])
      );

      assign ctl_flat[32*c +: 32] = ctl_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data is captured in the setup cycle and held through the access
  wire [1:0]  rsel = paddr[3:2];
  wire [47:0] cnt_sel = cnt_flat[48*rsel +: 48];
  reg  [31:0] rd_mux;

  // status word shows queue state straight from the queues
  wire [31:0] stat_word = {12'h000, wq_nonempty, wq_full,
                           2'b00, wq_occ[11:6], 2'b00, wq_occ[5:0]};

  always @*
  begin
    rd_mux = 32'h00000000;
    if (in_map)
    begin
      case (paddr[5:4])
        2'b00:   rd_mux = ctl_flat[32*rsel +: 32];
        2'b01:   rd_mux = cnt_sel[31:0];
        2'b10:   rd_mux = {16'h0000, cnt_sel[47:32]};
        default: rd_mux = stat_word;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h00000000;
    else if (setup & ~pwrite)
      prdata_reg <= rd_mux;
  end

endmodule // mwq_event_select
`default_nettype wire

// >>> mwq_select_props.sv
`default_nettype none
module mwq_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  input wire logic [1:0]  wq_wr_valid,
  input wire logic [31:0] wq_wr_addr,
  input wire logic [63:0] wq_wr_data,
  input wire logic [7:0]  wq_wr_be,
  input wire logic [1:0]  wq_wr_ready,
  input wire logic [1:0]  wq_wr_posted,
  input wire logic [1:0]  wq_rd_valid,
  input wire logic [31:0] wq_rd_addr,
  input wire logic [1:0]  wq_rd_done,
  input wire logic [1:0]  wq_rd_hit,
  input wire logic [63:0] wq_rd_data,
  input wire logic [1:0]  wq_iss_valid,
  input wire logic [31:0] wq_iss_addr,
  input wire logic [1:0]  wq_iss_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // write accepted on channel zero
  wire logic acc0 = wq_wr_valid[0] & wq_wr_ready[0];
  ////////////////////////////////////////////////////////////
  property p_err;
    psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h30) |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("bad address not refused");
  property p_err_only;
    !(psel && penable) |-> !pslverr;
  endproperty
  a_err_only: assert property (p_err_only) else $error("error outside access");
  property p_post;
    acc0 |=> wq_wr_posted[0];
  endproperty
  a_post: assert property (p_post) else $error("posted pulse missing");
  // search answer comes exactly one cycle after the request
  property p_done;
    1'b1 |=> wq_rd_done[0] == $past(wq_rd_valid[0]);
  endproperty
  a_done: assert property (p_done) else $error("read search answer off");
  property p_hit;
    acc0 && wq_wr_be[3:0] == 4'hF ##1 wq_rd_valid[0] && !wq_iss_ready[0]
      && wq_rd_addr[15:0] == $past(wq_wr_addr[15:0])
      |=> wq_rd_hit[0] && wq_rd_data[31:0] == $past(wq_wr_data[31:0], 2);
  endproperty
  a_hit: assert property (p_hit) else $error("read missed queued write");
  property p_alloc;
    acc0 ##1 !wq_wr_valid[0] |-> wq_iss_valid[0];
  endproperty
  a_alloc: assert property (p_alloc) else $error("entry not held");
  // an entry stays put until dram takes it
  property p_hold;
    wq_iss_valid[0] && !wq_iss_ready[0] && !wq_wr_valid[0]
      |=> wq_wr_valid[0] || wq_iss_valid[0] && $stable(wq_iss_addr[15:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("entry freed before issue");
  property p_full;
    !wq_wr_ready[0] |-> wq_iss_valid[0];
  endproperty
  a_full: assert property (p_full) else $error("refused while empty");
endmodule // mwq_props
bind mwq_event_select mwq_props mwq_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .wq_wr_valid(wq_wr_valid),
  .wq_wr_addr(wq_wr_addr), .wq_wr_data(wq_wr_data), .wq_wr_be(wq_wr_be),
  .wq_wr_ready(wq_wr_ready), .wq_wr_posted(wq_wr_posted), .wq_rd_valid(wq_rd_valid),
  .wq_rd_addr(wq_rd_addr), .wq_rd_done(wq_rd_done), .wq_rd_hit(wq_rd_hit),
  .wq_rd_data(wq_rd_data), .wq_iss_valid(wq_iss_valid), .wq_iss_addr(wq_iss_addr),
  .wq_iss_ready(wq_iss_ready));
`default_nettype wire

// >>> mwq_far_model.sv
`default_nettype none
module mwq_far_model (
  input  wire logic [0:0] pclk,
  input  wire logic       presetn,
  input  wire logic       stall,
  input  wire logic [1:0] wr_req,
  input  wire logic [1:0] wr_ready,
  output wire logic [1:0] wr_valid,
  input  wire logic [1:0] iss_valid,
  output logic      [1:0] iss_ready,
  output logic      [7:0] iss_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // home agent keeps new writes back while the queue refuses them
  assign wr_valid = wr_req & wr_ready;
  // dram side: stalls on demand, else takes issues on random cycles
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      iss_ready <= 2'h0;
      iss_cnt <= 8'h00;
    end
    else
    begin
      iss_cnt <= iss_cnt + 8'(iss_valid[0] & iss_ready[0]) + 8'(iss_valid[1] & iss_ready[1]);
      iss_ready <= stall ? 2'h0 : 2'($urandom);
    end
endmodule // mwq_far_model
`default_nettype wire

// >>> mwq_event_select_tb.sv
`default_nettype none
module mwq_event_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, stall;
  logic [7:0]  paddr, wq_wr_be, sb_marked_req, um;
  logic [31:0] pwdata, wq_wr_addr, wq_rd_addr, rd_v, d5;
  logic [63:0] wq_wr_data;
  logic [1:0]  wr_req, wq_rd_valid, chm;
  logic [4:0]  sb_starve_release, near_cache_lookup;
  logic [29:0] sb_starve_fill_cnt;
  logic [47:0] ex;
  logic        rd_err;
  wire logic [31:0] prdata_reg, wq_iss_addr;
  wire logic        pready, pslverr;
  wire logic [1:0]  wq_wr_valid, wq_wr_ready, wq_wr_posted, wq_rd_done, wq_rd_hit;
  wire logic [1:0]  wq_iss_valid, wq_iss_ready;
  wire logic [63:0] wq_rd_data, wq_iss_data;
  wire logic [7:0]  wq_iss_be, iss_cnt;
  int          bad_count, num_checks, cyc, t_acc, n, te[4], td[4];
  logic [7:0]  sbc[4] = '{8'hDE, 8'hD8, 8'hDD, 8'hD3};
  logic [7:0]  qc[8] = '{8'h20, 8'h82, 8'h22, 8'h24, 8'h21, 8'h83, 8'h16, 8'h23};
  mwq_event_select mwq_event_select_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_reg(prdata_reg), .pready(pready), .pslverr(pslverr), .wq_wr_valid(wq_wr_valid),
    .wq_wr_addr(wq_wr_addr), .wq_wr_data(wq_wr_data), .wq_wr_be(wq_wr_be),
    .wq_wr_ready(wq_wr_ready), .wq_wr_posted(wq_wr_posted), .wq_rd_valid(wq_rd_valid),
    .wq_rd_addr(wq_rd_addr), .wq_rd_done(wq_rd_done), .wq_rd_hit(wq_rd_hit),
    .wq_rd_data(wq_rd_data), .wq_iss_valid(wq_iss_valid), .wq_iss_addr(wq_iss_addr),
    .wq_iss_data(wq_iss_data), .wq_iss_be(wq_iss_be), .wq_iss_ready(wq_iss_ready),
    .sb_starve_release(sb_starve_release), .sb_starve_fill_cnt(sb_starve_fill_cnt),
    .sb_marked_req(sb_marked_req), .near_cache_lookup(near_cache_lookup));
  mwq_far_model mwq_far_model_i (.pclk(pclk), .presetn(presetn), .stall(stall),
    .wr_req(wr_req), .wr_ready(wq_wr_ready), .wr_valid(wq_wr_valid),
    .iss_valid(wq_iss_valid), .iss_ready(wq_iss_ready), .iss_cnt(iss_cnt));
  ////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // edge counter gives each apb access edge a number
  always @(posedge pclk)
    cyc <= cyc + 1;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [47:0] s, input logic [47:0] e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k == 50)
    begin
      bad_count++;
      report_and_stop();
    end
    rd_v = prdata_reg;
    rd_err = pslverr;
    t_acc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // per-cycle increment of the scoreboard and tag check events
  function automatic logic [8:0] sb_inc(input logic [7:0] c, input logic [7:0] u);
    logic [8:0] s = 9'h000;
    logic [47:0] f = 48'(sb_starve_fill_cnt);
    logic [7:0] r = 8'(sb_starve_release);
    logic [7:0] l = 8'(near_cache_lookup);
    for (int k = 0; k < 8; k++)
      if (u[k])
        s += (c == 8'hD8) ? 9'(f[6*k +: 6]) * 9'(k < 5)
          : 9'(c == 8'hDE ? r[k] : c == 8'hDD ? sb_marked_req[k] : l[k]);
    if (c == 8'hD8)
      return (s > 9'h03F) ? 9'h03F : s;
    return (c == 8'hDD) ? s : 9'(s != 9'h000);
  endfunction
  // queue event count of pass p between enable edge s and disable edge e, fill after b
  function automatic logic [47:0] q_exp(input int p, input int q, input int s, input int e,
                                        input int b);
    logic [47:0] x = 48'h0;
    int o;
    for (int t = s + 1; t <= e; t++)
    begin
      o = (t - b - 1 < 0) ? 0 : (t - b - 1 > 40) ? 40 : t - b - 1;
      x += (q == 0) ? 48'(t >= b + 2 && (p == 1 || t <= b + 41))
        : (q == 1) ? 48'(o) : (q == 2) ? 48'(o == 40)
        : (p == 1) ? 48'(t >= b + 3 && t <= b + 41 || t == b + 44) : 48'(t == b + 42);
    end
    return x;
  endfunction
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, stall, wr_req} = '0;
    {wq_wr_addr, wq_wr_data, wq_wr_be, wq_rd_valid, wq_rd_addr} = '0;
    {sb_starve_release, sb_starve_fill_cnt, sb_marked_req, near_cache_lookup} = '0;
    {bad_count, num_checks} = '0;
    void'($urandom(32'h398EC60A));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // every mapped word resets to zero; past the map the bus refuses
    for (int a = 0; a <= 52; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      check("reset word", (a == 52) ? 48'(rd_err) : 48'(rd_v), 48'(a == 52));
    end
    // scoreboard and tag events under random strobes; first mask all ones
    for (int i = 0; i < 4; i++)
    begin
      um = (i == 0) ? 8'hFF : 8'($urandom);
      apb(1'b1, 8'h00, {8'h00, 8'h42, um, sbc[i]});
      ex = 48'h0;
      for (int k = 0; k < 30; k++)
      begin
        sb_starve_release <= 5'($urandom);
        sb_starve_fill_cnt <= 30'($urandom);
        sb_marked_req <= 8'($urandom);
        near_cache_lookup <= 5'($urandom);
        @(posedge pclk);
        ex += 48'(sb_inc(sbc[i], um));
      end
      {sb_starve_release, sb_starve_fill_cnt, sb_marked_req, near_cache_lookup} <= '0;
      apb(1'b1, 8'h00, {16'h0000, um, sbc[i]});
      apb(1'b0, 8'h10, 32'h0);
      check("scoreboard count", 48'(rd_v), ex);
    end
    // fill one channel with dram stalled, reading back each previous write;
    // pass 0 runs channel zero, pass 1 channel one with the other queue events
    for (int p = 0; p < 2; p++)
    begin
      chm = p ? 2'h2 : 2'h1;
      stall <= 1'b1;
      for (int q = 0; q < 4; q++)
      begin
        apb(1'b1, 8'(4*q), {16'h0042, 6'h00, chm, qc[4*p+q]});
        te[q] = t_acc;
      end
      for (int k = 0; k < 40; k++)
      begin
        wr_req <= chm;
        wq_wr_addr <= {2{16'(k)}};
        wq_wr_be <= 8'hFF;
        wq_wr_data <= {$urandom, $urandom};
        wq_rd_valid <= (k > 0) ? chm : 2'h0;
        wq_rd_addr <= {2{16'(k - 1)}};
        @(posedge pclk);
        d5 = (k == 5) ? wq_wr_data[32*p +: 32] : d5;
      end
      // partial write merging into a full queue, then a new address refused
      wq_wr_addr <= 32'h00050005;
      wq_wr_be <= 8'h33;
      wq_wr_data <= 64'h0000123400001234;
      wq_rd_valid <= 2'h0;
      @(posedge pclk);
      wq_wr_addr <= 32'h00640064;
      wq_wr_be <= 8'hFF;
      #1;
      check("full refusal", 48'({wq_wr_ready[p], wq_wr_valid[p]}), 48'h0);
      @(posedge pclk);
      wr_req <= 2'h0;
      wq_rd_valid <= chm;
      wq_rd_addr <= 32'h00050005;
      @(posedge pclk);
      wq_rd_valid <= 2'h0;
      #1;
      check("merged read", 48'({wq_rd_done[p], wq_rd_hit[p], wq_rd_data[32*p +: 32]}),
        48'({2'h3, d5[31:16], 16'h1234}));
      // oldest entry waits at the head with its full byte mask
      check("issue head",
        48'({wq_iss_valid[p], wq_iss_be[4*p +: 4], wq_iss_addr[16*p +: 16]}),
        48'h1F0000);
      for (int q = 0; q < 4; q++)
      begin
        apb(1'b1, 8'(4*q), 32'h0);
        td[q] = t_acc;
      end
      for (int q = 0; q < 4; q++)
      begin
        apb(1'b0, 8'(16 + 4*q), 32'h0);
        check("queue count", 48'(rd_v),
          q_exp(p, q, te[q], td[q], te[3]));
      end
      // drain with a randomly slow dram; merged write issues only once
      stall <= 1'b0;
      n = 0;
      do
      begin
        apb(1'b0, 8'h30, 32'h0);
        n++;
      end
      while (rd_v[13:0] !== 14'h0000 && n < 100);
      if (n == 100)
        bad_count++;
      check("issued", 48'(iss_cnt), 48'(40 * (p + 1)));
    end
    report_and_stop();
  end
endmodule // mwq_event_select_tb
`default_nettype wire
